// File: hw/fwg_pkg.sv
// shared constants and types for the flash write guard and lock
package fwg_pkg;
	localparam int          PAGE_BYTES        = 512;
	localparam int          ADDR_W            = 12;
	localparam int          PAGE_SHIFT        = 9;
	localparam int          PAGE_W            = ADDR_W - PAGE_SHIFT;
	localparam logic [7:0]  KEY_REG_ADDR      = 8'hb7;
	localparam logic [7:0]  CTRL_REG_ADDR     = 8'h8f;
	localparam logic [7:0]  KEY_RESET         = 8'h00;
	localparam logic [7:0]  KEY_FIRST         = 8'ha5;
	localparam logic [7:0]  KEY_SECOND        = 8'hf1;
	localparam int          CTRL_WE_BIT       = 0;
	localparam int          CTRL_EE_BIT       = 1;
	localparam logic [1:0]  ST_LOCKED         = 2'h0;
	localparam logic [1:0]  ST_FIRST          = 2'h1;
	localparam logic [1:0]  ST_UNLOCKED       = 2'h2;
	localparam logic [1:0]  ST_DISABLED       = 2'h3;
	localparam logic [ADDR_W-1:0] LOCK_BYTE_ADDR = 12'hfff;
	localparam logic [7:0]  LOCK_RESET        = 8'hff;
	localparam int          OPERATION_CYCLES  = 4;

	typedef enum logic [1:0] {
		FWG_OP_READ  = 2'h0,
		FWG_OP_WRITE = 2'h1,
		FWG_OP_ERASE = 2'h2
	} fwg_op_t;

	typedef enum logic [2:0] {
		FWG_IDLE = 3'b001,
		FWG_BUSY = 3'b010,
		FWG_DONE = 3'b100
	} fwg_host_state_t;
endpackage

// File: hw/fwg_if.sv
// interface joining the flash guard device to its firmware/debug requester
`timescale 1ns/10ps
interface fwg_if;
	import fwg_pkg::*;
	logic              req;
	logic              dbg;
	logic              from_locked;
	logic [1:0]        op;
	logic [ADDR_W-1:0] addr;
	logic [7:0]        wdata;
	logic              sfr_wr;
	logic              sfr_rd;
	logic [7:0]        sfr_addr;
	logic [7:0]        sfr_wdata;
	logic [7:0]        sfr_rdata;
	logic              done;
	logic              granted;
	logic              refused;
	logic              err_reset;
	logic [7:0]        rdata;
	modport device (input req, dbg, from_locked, op, addr, wdata, sfr_wr, sfr_rd, sfr_addr,
		sfr_wdata, output sfr_rdata, done, granted, refused, err_reset, rdata);
	modport host (output req, dbg, from_locked, op, addr, wdata, sfr_wr, sfr_rd, sfr_addr,
		sfr_wdata, input sfr_rdata, done, granted, refused, err_reset, rdata);
endinterface

// File: hw/fwg_device.sv
// flash guard device: key sequencer, enables, page lock decode and flash array
// Operation
// - flash split into 512-byte pages, whole-page erase
// - each byte programmed once between erases
// - firmware write needs write-enable bit set
// - firmware erase needs write and erase enables
// - first n pages locked, n inverted lock byte
// - lock byte page locked if any bit zero
// - unlocked pages open to debug and firmware
// - locked pages: debug refused, unlocked firmware resets
// - lock byte page follows lock policy if locked
// - key 0xa5 then 0xf1 arms one operation
// - armed state ends after one write/erase
// - bad key or unarmed attempt disables until reset
// - non-0xa5 first key deliberately disables flash
// - key register read shows two-bit lock state
// - access from debug port or external move path
`timescale 1ns/10ps
module fwg_device
	import fwg_pkg::*;
#(
	parameter int DEPTH = 4096
) (
	input  wire logic clk,
	input  wire logic rst,
	fwg_if.device     bus
);
	// key sequencer states; one-hot so a stray code is easy to catch
	typedef enum logic [3:0] {
		FWG_KEY_LOCKED   = 4'b0001,
		FWG_KEY_FIRST    = 4'b0010,
		FWG_KEY_UNLOCKED = 4'b0100,
		FWG_KEY_DISABLED = 4'b1000
	} fwg_key_state_t;

	logic [7:0]        mem [DEPTH];
	fwg_key_state_t    key_state;
	logic              store_write_enable;
	logic              store_erase_enable;
	logic [7:0]        lock_byte;
	logic [PAGE_W-1:0] pg;
	logic [8:0]        n_locked;
	logic              any_locked;
	logic              page_locked;
	logic              lock_page;
	logic              is_write;
	logic              is_erase;
	logic              modify;
	logic              prot_ok;
	logic              fw_err;
	logic              key_ok;
	logic              allow;
	logic              key_wr;
	logic              ctrl_wr;
	logic              do_write;
	logic              do_erase;
	logic              fw_try;

	// page number of an address
	function automatic logic [PAGE_W-1:0] page_of(input logic [ADDR_W-1:0] a);
		page_of = a[ADDR_W-1:PAGE_SHIFT];
	endfunction

	// two-bit lock code that software reads back
	function automatic logic [1:0] key_code(input fwg_key_state_t s);
		case (s)
			FWG_KEY_LOCKED:   key_code = ST_LOCKED;
			FWG_KEY_FIRST:    key_code = ST_FIRST;
			FWG_KEY_UNLOCKED: key_code = ST_UNLOCKED;
			default:          key_code = ST_DISABLED;
		endcase
	endfunction

	// lock decode from the stored lock byte
	assign n_locked   = {1'b0, ~lock_byte};
	assign any_locked = (lock_byte != LOCK_RESET);
	assign pg         = page_of(bus.addr);
	assign lock_page  = (pg == page_of(LOCK_BYTE_ADDR));
	assign page_locked = lock_page ? any_locked : ({6'h00, pg} < n_locked);
	assign is_write   = (bus.op == FWG_OP_WRITE);
	assign is_erase   = (bus.op == FWG_OP_ERASE);
	assign modify     = is_write | is_erase;

	// access policy by path and by where firmware runs
	always_comb begin
		prot_ok = 1'b1;
		fw_err  = 1'b0;
		if (page_locked) begin
			if (bus.dbg) begin
				prot_ok = 1'b0;
			end else if (!bus.from_locked) begin
				prot_ok = 1'b0;
				fw_err  = 1'b1;
			end
		end
	end

	// firmware enables and key arming; debug port bypasses the software enables
	assign key_ok = bus.dbg ? 1'b1 :
		(key_state == FWG_KEY_UNLOCKED) &&
		(store_write_enable && (!is_erase || store_erase_enable));
	assign allow   = prot_ok && (!modify || key_ok);
	assign key_wr  = bus.sfr_wr && (bus.sfr_addr == KEY_REG_ADDR);
	assign ctrl_wr = bus.sfr_wr && (bus.sfr_addr == CTRL_REG_ADDR);

	// granted modifies, and firmware modifies that reach the key check
	assign do_write = bus.req && allow && is_write;
	assign do_erase = bus.req && allow && is_erase;
	assign fw_try   = bus.req && modify && !bus.dbg && prot_ok;

	// program store control bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			store_write_enable <= 1'b0;
			store_erase_enable <= 1'b0;
		end else if (ctrl_wr) begin
			store_write_enable <= bus.sfr_wdata[CTRL_WE_BIT];
			store_erase_enable <= bus.sfr_wdata[CTRL_EE_BIT];
		end
	end

	// key sequencer; a clean reset always leaves it locked
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			key_state <= FWG_KEY_LOCKED;
		end else if (fw_try) begin
			// an armed use is consumed, an unarmed attempt disables until reset
			if (key_ok) begin
				key_state <= FWG_KEY_LOCKED;
			end else begin
				key_state <= FWG_KEY_DISABLED;
			end
		end else if (key_wr) begin
			case (key_state)
				FWG_KEY_LOCKED: begin
					if (bus.sfr_wdata == KEY_FIRST) begin
						key_state <= FWG_KEY_FIRST;
					end else begin
						key_state <= FWG_KEY_DISABLED;
					end
				end
				FWG_KEY_FIRST: begin
					if (bus.sfr_wdata == KEY_SECOND) begin
						key_state <= FWG_KEY_UNLOCKED;
					end else begin
						key_state <= FWG_KEY_DISABLED;
					end
				end
				// a third key write is a misuse, not a re-arm
				FWG_KEY_UNLOCKED: key_state <= FWG_KEY_DISABLED;
				FWG_KEY_DISABLED: key_state <= FWG_KEY_DISABLED;
				// a corrupted one-hot code fails closed
				default:          key_state <= FWG_KEY_DISABLED;
			endcase
		end
	end

	// register read data, one cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus.sfr_rdata <= KEY_RESET;
		end else if (bus.sfr_rd) begin
			case (bus.sfr_addr)
				KEY_REG_ADDR:  bus.sfr_rdata <= {6'h00, key_code(key_state)};
				CTRL_REG_ADDR: bus.sfr_rdata <= {6'h00, store_erase_enable,
					store_write_enable};
				default:       bus.sfr_rdata <= 8'h00;
			endcase
		end else begin
			bus.sfr_rdata <= 8'h00;
		end
	end

	// answer flags, one cycle after the request
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus.done      <= 1'b0;
			bus.granted   <= 1'b0;
			bus.refused   <= 1'b0;
			bus.err_reset <= 1'b0;
			bus.rdata     <= 8'h00;
		end else begin
			bus.done      <= bus.req;
			bus.granted   <= bus.req && allow;
			bus.refused   <= bus.req && !allow;
			bus.err_reset <= bus.req && fw_err;
			bus.rdata     <= (bus.req && allow && !modify) ? mem[bus.addr] : 8'h00;
		end
	end

	// flash array: writes only clear bits, erase sets a whole page
	always_ff @(posedge clk) begin
		if (do_write) begin
			mem[bus.addr] <= mem[bus.addr] & bus.wdata;
		end else if (do_erase) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				mem[{pg, i[PAGE_SHIFT-1:0]}] <= 8'hff;
			end
		end
	end

	// the lock byte follows writes and erases of its flash cell; reset loads 0xff, not the cell
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lock_byte <= LOCK_RESET;
		end else if (do_write && (bus.addr == LOCK_BYTE_ADDR)) begin
			lock_byte <= lock_byte & bus.wdata;
		end else if (do_erase && lock_page) begin
			lock_byte <= LOCK_RESET;
		end
	end
endmodule

// File: hw/fwg_host.sv
// requester end: issues one flash or register access per command
`timescale 1ns/10ps
module fwg_host
	import fwg_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	fwg_if.host                    bus,
	input  wire logic              cmd_go,
	input  wire logic [2:0]        cmd_kind,
	input  wire logic              cmd_dbg,
	input  wire logic              cmd_from_locked,
	input  wire logic [ADDR_W-1:0] cmd_addr,
	input  wire logic [7:0]        cmd_data,
	output logic                   busy,
	output logic [7:0]             result,
	output logic [1:0]             status
);
	fwg_host_state_t state;
	logic            flash_cmd;

	// kinds 0..2 are flash ops, 4 register write, 5 register read
	assign flash_cmd = !cmd_kind[2];
	assign busy      = (state != FWG_IDLE);

	// one request in flight; strobes last one cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state         <= FWG_IDLE;
			bus.req       <= 1'b0;
			bus.dbg       <= 1'b0;
			bus.from_locked <= 1'b0;
			bus.op        <= 2'h0;
			bus.addr      <= '0;
			bus.wdata     <= 8'h00;
			bus.sfr_wr    <= 1'b0;
			bus.sfr_rd    <= 1'b0;
			bus.sfr_addr  <= 8'h00;
			bus.sfr_wdata <= 8'h00;
		end else begin
			bus.req    <= 1'b0;
			bus.sfr_wr <= 1'b0;
			bus.sfr_rd <= 1'b0;
			case (state)
				FWG_IDLE: if (cmd_go) begin
					state           <= FWG_BUSY;
					bus.dbg         <= cmd_dbg;
					bus.from_locked <= cmd_from_locked;
					bus.op          <= cmd_kind[1:0];
					bus.addr        <= cmd_addr;
					bus.wdata       <= cmd_data;
					bus.sfr_addr    <= cmd_addr[7:0];
					bus.sfr_wdata   <= cmd_data;
					bus.req         <= flash_cmd;
					bus.sfr_wr      <= (cmd_kind == 3'h4);
					bus.sfr_rd      <= (cmd_kind == 3'h5);
				end
				FWG_BUSY: state <= FWG_DONE;
				FWG_DONE: state <= FWG_IDLE;
				default:  state <= FWG_IDLE;
			endcase
		end
	end

	// capture the answer while it stands, two edges after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			result <= 8'h00;
			status <= 2'h0;
		end else if (state == FWG_DONE) begin
			result <= bus.done ? bus.rdata : bus.sfr_rdata;
			status <= {bus.err_reset, bus.refused};
		end
	end
endmodule

// File: bench/fwg_chk.sv
// concurrent checks on the flash guard interface
`timescale 1ns/10ps
module fwg_chk
	import fwg_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       req,
	input wire logic       dbg,
	input wire logic       from_locked,
	input wire logic [1:0] op,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_rdata,
	input wire logic       done,
	input wire logic       granted,
	input wire logic       refused,
	input wire logic       err_reset
);
	logic dis;
	logic fresh;
	logic rd_d;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// disabled once seen, kept only until the next reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dis <= 1'b0;
			fresh <= 1'b1;
			rd_d <= 1'b0;
		end else begin
			rd_d <= sfr_rd && sfr_addr == KEY_REG_ADDR;
			if (rd_d && sfr_rdata[1:0] == ST_DISABLED)
				dis <= 1'b1;
			if (sfr_wr || req)
				fresh <= 1'b0;
		end
	end
	sequence s_key_rd;
		sfr_rd && sfr_addr == KEY_REG_ADDR;
	endsequence
	sequence s_fw_change;
		req && !dbg && op != FWG_OP_READ;
	endsequence
	a_answer_next: assert property (req |=> done && granted != refused)
		else $error("request not answered");
	a_idle_quiet: assert property (!req |=> !done && !granted && !refused)
		else $error("answer without request");
	a_debug_no_reset: assert property (req && dbg |=> !err_reset)
		else $error("error reset on debug access");
	a_locked_fw_ok: assert property (req && !dbg && from_locked |=> !err_reset)
		else $error("error reset for locked code");
	a_reset_refused: assert property (err_reset |-> refused)
		else $error("error reset not refused");
	a_stays_disabled: assert property (s_fw_change ##0 dis |=> !granted)
		else $error("granted while disabled");
	a_disabled_reads: assert property (s_key_rd ##0 dis |=> sfr_rdata[1:0] == ST_DISABLED)
		else $error("disabled state left");
	a_fresh_locked: assert property (s_key_rd ##0 fresh |=> sfr_rdata[1:0] == ST_LOCKED)
		else $error("key state not locked after reset");
	a_key_upper_zero: assert property (s_key_rd |=> sfr_rdata[7:2] == 6'h00)
		else $error("key upper bits set");
	a_read_quiet: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
		else $error("read data without read");
endmodule

// File: bench/flash_write_guard_and_lock_test.sv
// self-checking bench for the flash guard device and requester
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected %0t got %h want %h", $time, g, e); end end
module flash_write_guard_and_lock_test;
	import fwg_pkg::*;
	logic              clk = 1'b0, rst = 1'b1, go = 1'b0, c_dbg = 1'b0, c_fl = 1'b0, busy;
	logic [2:0]        kind = 3'h0;
	logic [ADDR_W-1:0] c_addr = 12'h000;
	logic [7:0]        c_data = 8'h00, result;
	logic [1:0]        status;
	int                bad_count = 0, total_checks = 0, cyc = 0, seed = 32'h5190;
	int                ks, we, ee, lb, p, m, q, r;
	int                mem[int];
	fwg_if bus_if();
	always #25 clk = ~clk;
	// hang guard, far above the roughly 660 cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			test_done();
		end
	end
	fwg_device fwg_device_inst (.clk(clk), .rst(rst), .bus(bus_if));
	fwg_host fwg_host_inst (.clk(clk), .rst(rst), .bus(bus_if), .cmd_go(go), .cmd_kind(kind),
		.cmd_dbg(c_dbg), .cmd_from_locked(c_fl), .cmd_addr(c_addr), .cmd_data(c_data),
		.busy(busy), .result(result), .status(status));
	fwg_chk fwg_chk_inst (.clk(clk), .rst(rst), .req(bus_if.req), .dbg(bus_if.dbg),
		.from_locked(bus_if.from_locked), .op(bus_if.op), .sfr_wr(bus_if.sfr_wr),
		.sfr_rd(bus_if.sfr_rd), .sfr_addr(bus_if.sfr_addr), .sfr_rdata(bus_if.sfr_rdata),
		.done(bus_if.done), .granted(bus_if.granted), .refused(bus_if.refused),
		.err_reset(bus_if.err_reset));
	task test_done;
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// the array keeps its contents over reset, the lock copy does not
	task rst_pulse(input int n);
		@(posedge clk);
		rst <= 1'b1;
		repeat (n) @(posedge clk);
		rst <= 1'b0;
		{ks, we, ee, lb} = {32'd0, 32'd0, 32'd0, 32'd255};
	endtask
	// one command through the requester, then the model's verdict
	task run(input int k, d, f, a, v);
		int pg, ok, xr;
		logic [1:0] xs;
		@(posedge clk);
		{go, kind, c_dbg, c_fl} <= {1'b1, k[2:0], d[0], f[0]};
		{c_addr, c_data} <= {a[ADDR_W-1:0], v[7:0]};
		@(posedge clk);
		go <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			@(posedge clk);
			#1;
			if (busy !== 1'b1)
				break;
		end
		xs = 2'h0;
		xr = -1;
		pg = a >> PAGE_SHIFT;
		ok = !(pg < (~lb & 255) || (pg == 7 && lb != 255)) || (f && !d);
		if (k == 5)
			xr = a == KEY_REG_ADDR ? ks : a == CTRL_REG_ADDR ? ee * 2 + we : 0;
		else if (k == 4) begin
			if (a == KEY_REG_ADDR)
				ks = ks == 0 && v == KEY_FIRST ? 1 : ks == 1 && v == KEY_SECOND ? 2 : 3;
			if (a == CTRL_REG_ADDR)
				{we, ee} = {v & 1, v >> 1 & 1};
		end else if (!ok)
			xs = d ? 2'h1 : 2'h3;
		else if (!d && k != 0) begin
			ok = ks == 2 && we && (k == 1 || ee);
			xs = ok ? 2'h0 : 2'h1;
			ks = ok ? 0 : 3;
		end
		// writes only clear bits, erase sets a whole page
		if (k < 4 && ok) begin
			if (k == 0 && mem.exists(a))
				xr = mem[a];
			if (k == 1 && mem.exists(a))
				mem[a] &= v;
			if (k == 1 && a == LOCK_BYTE_ADDR)
				lb &= v;
			for (int i = 0; k == 2 && i < PAGE_BYTES; i++)
				mem[pg * PAGE_BYTES + i] = 255;
			if (k == 2 && pg == 7)
				lb = 255;
		end
		if (xr >= 0) `CHK(result, xr[7:0])
		if (k < 4) `CHK(status, xs)
	endtask
	initial begin
		rst_pulse(8);
		run(5, 0, 0, KEY_REG_ADDR, 0);
		run(5, 0, 0, 8'h10, 0);
		run(1, 0, 0, 600, 8'h3c);
		run(5, 0, 0, KEY_REG_ADDR, 0);
		for (p = 0; p < 8; p++)
			run(2, 1, 0, p * PAGE_BYTES, 0);
		// every enable pair against one armed write or erase, then an unarmed one
		for (m = 0; m < 8; m++) begin
			rst_pulse(1);
			r = 1024 + m * 64 + ($random(seed) & 63);
			run(4, 0, 0, CTRL_REG_ADDR, m & 3);
			run(5, 0, 0, CTRL_REG_ADDR, 0);
			run(4, 0, 0, KEY_REG_ADDR, KEY_FIRST);
			run(4, 0, 0, KEY_REG_ADDR, KEY_SECOND);
			run(5, 0, 0, KEY_REG_ADDR, 0);
			run(m < 4 ? 1 : 2, 0, 0, r, $random(seed) & 255);
			run(5, 0, 0, KEY_REG_ADDR, 0);
			run(0, 1, 0, r, 0);
			run(m < 4 ? 1 : 2, 0, 0, r, 0);
			run(5, 0, 0, KEY_REG_ADDR, 0);
		end
		// wrong first key, wrong second key, and a key write once armed
		for (m = 0; m < 3; m++) begin
			rst_pulse(1);
			run(5, 0, 0, KEY_REG_ADDR, 0);
			run(4, 0, 0, KEY_REG_ADDR, m ? KEY_FIRST : 8'h5a);
			run(4, 0, 0, KEY_REG_ADDR, m == 1 ? 8'h00 : m ? KEY_SECOND : KEY_FIRST);
			if (m == 2)
				run(5, 0, 0, KEY_REG_ADDR, 0);
			if (m == 2)
				run(4, 0, 0, KEY_REG_ADDR, KEY_SECOND);
			run(5, 0, 0, KEY_REG_ADDR, 0);
		end
		// all paths over all pages, open and then with pages 0, 1 and the lock byte page locked
		for (q = 0; q < 2; q++) begin
			if (q)
				rst_pulse(1);
			if (q)
				run(2, 1, 0, LOCK_BYTE_ADDR, 0);
			if (q)
				run(1, 1, 0, LOCK_BYTE_ADDR, 8'hfd);
			for (p = 0; p < 24; p++) begin
				r = $random(seed);
				// offsets kept apart so no byte is programmed twice between erases
				run(r & 1, p % 3 == 0, p % 3 == 2, p / 3 * 512 + 256 + q * 128 +
					p % 3 * 32 + (r >> 8 & 31), r >> 20 & 255);
			end
		end
		test_done();
	end
endmodule
